/* File: rtl/lec_regs.svh */
// register offsets, field positions, reset values for the led engine config bank
`ifndef LEC_REGS_SVH
`define LEC_REGS_SVH
`define LEC_OFS_DIMMER3     8'h4a
`define LEC_OFS_START1      8'h4c
`define LEC_OFS_START2      8'h4d
`define LEC_OFS_START3      8'h4e
`define LEC_OFS_PAGE        8'h4f
`define LEC_OFS_MAP_UPPER   8'h70
`define LEC_OFS_MAP_LOWER   8'h71
`define LEC_OFS_WIN_BASE    8'h50
`define LEC_RST_BYTE        8'h00
`define LEC_START_W         7
`define LEC_PAGE_W          3
`define LEC_PAGE_WORDS      16
`define LEC_PAGE_COUNT      6
`define LEC_MAP_AUX_BIT     7
`define LEC_MAP_OUT9_BIT    0
`endif

/* File: rtl/lec_pkg.sv */
// types shared by the led engine config bank
package lec_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lec_req_type;

    typedef struct packed {
        logic       aux;
        logic [8:0] outs;
    } lec_map_type;
endpackage : lec_pkg

/* File: rtl/lec_code_mem.sv */
// paged program memory with its own array
`timescale 1ns/1ps
`include "lec_regs.svh"
module lec_code_mem #(
    parameter int WORD_W = 16,
    parameter int DEPTH  = 96
) (
    input  wire logic              clk_sys,
    input  wire logic              we,
    input  wire logic [6:0]        waddr,
    input  wire logic [WORD_W-1:0] wdata,
    input  wire logic [6:0]        raddr,
    output logic      [WORD_W-1:0] rdata
);
    logic [WORD_W-1:0] mem [DEPTH];

    // no reset on the array: program contents are loaded by software
    always_ff @(posedge clk_sys) begin
        if (we && (int'(waddr) < DEPTH)) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (int'(raddr) < DEPTH) begin
            rdata <= mem[raddr];
        end else begin
            rdata <= '0;
        end
    end
endmodule : lec_code_mem

/* File: rtl/lec_config_regs.sv */
// register bank: group dimmer, engine start addresses, page select, engine 1 map
`timescale 1ns/1ps
`include "lec_regs.svh"
module lec_config_regs (
    input  wire logic                clk_sys,
    input  wire logic                srst,
    input  wire lec_pkg::lec_req_type req,
    input  wire lec_pkg::lec_map_type engine_one_map,
    output logic      [7:0]          rdata,
    output logic                     rvalid,
    output logic      [7:0]          group_dimmer_three,
    output logic      [6:0]          engine_one_start_address,
    output logic      [6:0]          engine_two_start_address,
    output logic      [6:0]          engine_three_start_address,
    output logic      [2:0]          code_page,
    output logic      [6:0]          code_rd_addr
);
    import lec_pkg::*;

    logic [7:0] dimmer_reg;
    logic [6:0] start1_reg;
    logic [6:0] start2_reg;
    logic [6:0] start3_reg;
    logic [2:0] page_reg;
    logic [9:0] map_reg;
    logic [7:0] rdata_reg;
    logic       rvalid_reg;
    logic       win_hit;
    logic       page_ok;
    logic [6:0] win_addr;
    logic       mem_rd_pend_reg;
    logic       mem_we;
    logic [7:0] mem_rdata;

    // -----------------------------------------------------------------
    // program window decode
    // -----------------------------------------------------------------
    assign win_hit  = (req.addr >= `LEC_OFS_WIN_BASE) &&
                      (req.addr <  (`LEC_OFS_WIN_BASE + 8'(`LEC_PAGE_WORDS)));
    assign page_ok  = (int'(page_reg) < `LEC_PAGE_COUNT);
    // 16n + offset: page code forms the high bits of the word address
    assign win_addr = {page_reg, req.addr[3:0]};
    assign mem_we   = req.wr && win_hit && page_ok;
    assign code_rd_addr = win_addr;

    // -----------------------------------------------------------------
    // program memory
    // -----------------------------------------------------------------
    // array lives here so window writes persist across page changes
    lec_code_mem #(
        .WORD_W (8),
        .DEPTH  (`LEC_PAGE_WORDS * `LEC_PAGE_COUNT)
    ) u_mem (
        .clk_sys (clk_sys),
        .we      (mem_we),
        .waddr   (win_addr),
        .wdata   (req.wdata),
        .raddr   (win_addr),
        .rdata   (mem_rdata)
    );

    // -----------------------------------------------------------------
    // writable registers and the read-only engine 1 map
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dimmer_reg <= `LEC_RST_BYTE;
        end else if (req.wr && req.addr == `LEC_OFS_DIMMER3) begin
            dimmer_reg <= req.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            start1_reg <= '0;
            start2_reg <= '0;
            start3_reg <= '0;
        end else if (req.wr) begin
            // upper bit dropped on write so it always reads zero
            if (req.addr == `LEC_OFS_START1) start1_reg <= req.wdata[6:0];
            if (req.addr == `LEC_OFS_START2) start2_reg <= req.wdata[6:0];
            if (req.addr == `LEC_OFS_START3) start3_reg <= req.wdata[6:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            page_reg <= '0;
        end else if (req.wr && req.addr == `LEC_OFS_PAGE) begin
            // codes 6 and 7 are kept; the window decode refuses them
            page_reg <= req.wdata[2:0];
        end
    end

    // map status follows engine 1; host writes never reach it
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            map_reg <= '0;
        end else begin
            map_reg <= {engine_one_map.aux, engine_one_map.outs};
        end
    end

    // -----------------------------------------------------------------
    // read path, one cycle latency; window reads one more
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mem_rd_pend_reg <= 1'b0;
        end else begin
            mem_rd_pend_reg <= req.rd && win_hit && page_ok;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else if (mem_rd_pend_reg) begin
            rdata_reg  <= mem_rdata;
            rvalid_reg <= 1'b1;
        end else if (req.rd && !(win_hit && page_ok)) begin
            // pages 6 and 7 land here and read zero in one cycle
            rvalid_reg <= 1'b1;
            case (req.addr)
                `LEC_OFS_DIMMER3:   rdata_reg <= dimmer_reg;
                `LEC_OFS_START1:    rdata_reg <= {1'b0, start1_reg};
                `LEC_OFS_START2:    rdata_reg <= {1'b0, start2_reg};
                `LEC_OFS_START3:    rdata_reg <= {1'b0, start3_reg};
                `LEC_OFS_PAGE:      rdata_reg <= {5'h00, page_reg};
                `LEC_OFS_MAP_UPPER: rdata_reg <= {map_reg[9], 6'h00, map_reg[8]};
                `LEC_OFS_MAP_LOWER: rdata_reg <= map_reg[7:0];
                default:            rdata_reg <= 8'h00;
            endcase
        end else begin
            rvalid_reg <= 1'b0;
        end
    end

    assign rdata  = rdata_reg;
    assign rvalid = rvalid_reg;
    assign group_dimmer_three         = dimmer_reg;
    assign engine_one_start_address   = start1_reg;
    assign engine_two_start_address   = start2_reg;
    assign engine_three_start_address = start3_reg;
    assign code_page                  = page_reg;

    // -----------------------------------------------------------------
    // checks: reset and register writes
    // -----------------------------------------------------------------
    // no disable here, so the clear itself is what gets checked
    a_reset_values: assert property (@(posedge clk_sys)
        srst |=> dimmer_reg == 8'h00 && start1_reg == 7'h00 && start2_reg == 7'h00
        && start3_reg == 7'h00 && page_reg == 3'h0 && map_reg == 10'h000 && !rvalid)
        else $error("register not cleared by reset");

    a_dimmer_write: assert property (@(posedge clk_sys) disable iff (srst)
        req.wr && req.addr == `LEC_OFS_DIMMER3 |=> group_dimmer_three == $past(req.wdata))
        else $error("dimmer write lost");

    a_start1_write: assert property (@(posedge clk_sys) disable iff (srst)
        req.wr && req.addr == `LEC_OFS_START1 |=> start1_reg == $past(req.wdata[6:0]))
        else $error("start1 write lost");

    a_start2_write: assert property (@(posedge clk_sys) disable iff (srst)
        req.wr && req.addr == `LEC_OFS_START2 |=> start2_reg == $past(req.wdata[6:0]))
        else $error("start2 write lost");

    a_start3_write: assert property (@(posedge clk_sys) disable iff (srst)
        req.wr && req.addr == `LEC_OFS_START3 |=> start3_reg == $past(req.wdata[6:0]))
        else $error("start3 write lost");

    a_page_write: assert property (@(posedge clk_sys) disable iff (srst)
        req.wr && req.addr == `LEC_OFS_PAGE |=> code_page == $past(req.wdata[2:0]))
        else $error("page write lost");

    a_bad_page_nowr: assert property (@(posedge clk_sys) disable iff (srst)
        page_reg > 3'h5 |-> !mem_we)
        else $error("write on invalid page");

    // -----------------------------------------------------------------
    // checks: register reads
    // -----------------------------------------------------------------
    a_dimmer_read: assert property (@(posedge clk_sys) disable iff (srst)
        req.rd && req.addr == `LEC_OFS_DIMMER3 |=> rvalid && rdata == $past(dimmer_reg))
        else $error("dimmer read wrong");

    a_start2_read: assert property (@(posedge clk_sys) disable iff (srst)
        req.rd && req.addr == `LEC_OFS_START2 |=> rvalid && rdata == {1'b0, $past(start2_reg)})
        else $error("start2 read wrong");

    a_page_read: assert property (@(posedge clk_sys) disable iff (srst)
        req.rd && req.addr == `LEC_OFS_PAGE |=> rvalid && rdata[7:3] == 5'h00)
        else $error("page upper bits not zero");

    a_start_top_zero: assert property (@(posedge clk_sys) disable iff (srst)
        req.rd && req.addr == `LEC_OFS_START1 |=> rdata[7] == 1'b0)
        else $error("start upper bit not zero");

    a_upper_map_read: assert property (@(posedge clk_sys) disable iff (srst)
        req.rd && req.addr == `LEC_OFS_MAP_UPPER |=> rvalid && rdata[6:1] == 6'h00
        && rdata[7] == $past(map_reg[9]) && rdata[0] == $past(map_reg[8]))
        else $error("upper map read wrong");

    a_lower_map_read: assert property (@(posedge clk_sys) disable iff (srst)
        req.rd && req.addr == `LEC_OFS_MAP_LOWER |=> rvalid && rdata == $past(map_reg[7:0]))
        else $error("lower map read wrong");

    // each lower-map output bit (outs 0 to 7) traced from the engine level two edges back
    for (genvar b = 0; b < 8; b++) begin : g_map_bit
        a_map_bit_read: assert property (@(posedge clk_sys) disable iff (srst)
            req.rd && req.addr == `LEC_OFS_MAP_LOWER && !$past(srst)
            |=> rdata[b] == $past(engine_one_map.outs[b], 2))
            else $error("map bit read wrong");
    end

    a_window_latency: assert property (@(posedge clk_sys) disable iff (srst)
        req.rd && win_hit && page_ok |=> !rvalid ##1 rvalid)
        else $error("window read answer late");

    a_bad_page_read: assert property (@(posedge clk_sys) disable iff (srst)
        req.rd && win_hit && page_reg > 3'h5 |=> rvalid && rdata == 8'h00)
        else $error("invalid page read not zero");
endmodule : lec_config_regs

/* File: sim/lec_code_model.sv */
// window address echo: shows which program word page and offset point at
`timescale 1ns/1ps
module lec_code_model (
    input  wire logic       clk_sys,
    input  wire logic [6:0] code_rd_addr,
    output logic      [7:0] code_rd_data
);
    // word carries its own address, so a wrong page or offset is seen
    always_ff @(posedge clk_sys) begin
        code_rd_data <= {1'b1, code_rd_addr};
    end
endmodule : lec_code_model

/* File: sim/lec_config_regs_tb.sv */
// self-checking bench for the led engine config register bank
`timescale 1ns/1ps
module lec_config_regs_tb;
    import lec_pkg::*;
    logic        clk_sys;
    logic        srst;
    lec_req_type req;
    lec_map_type map;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [7:0]  dim3;
    logic [6:0]  st1;
    logic [6:0]  st2;
    logic [6:0]  st3;
    logic [2:0]  page;
    logic [6:0]  crd_addr;
    logic [7:0]  crd_data;
    int          fails;
    int          samples_checked;
    int          cycles;

    lec_config_regs dut (.clk_sys(clk_sys), .srst(srst), .req(req),
        .engine_one_map(map), .rdata(rdata), .rvalid(rvalid),
        .group_dimmer_three(dim3), .engine_one_start_address(st1),
        .engine_two_start_address(st2), .engine_three_start_address(st3),
        .code_page(page), .code_rd_addr(crd_addr));
    lec_code_model mem (.clk_sys(clk_sys), .code_rd_addr(crd_addr),
        .code_rd_data(crd_data));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // generous ceiling: the whole sequence needs a few hundred cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles > 5000) begin
            fails = fails + 1;
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_sys);
        req.wr = 1'b0;
    endtask : wr

    // waits a bounded number of cycles for the registered answer
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        int n;
        @(negedge clk_sys);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_sys);
        req.rd = 1'b0;
        for (n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge clk_sys);
        chk((rvalid === 1'b1) ? rdata : 8'hxx, e);
        @(negedge clk_sys);
    endtask : rd

    initial begin
        fails = 0;
        samples_checked = 0;
        cycles = 0;
        req = '0;
        map = '0;
        srst = 1'b1;
        repeat (20) @(negedge clk_sys);
        srst = 1'b0;
        rd(8'h4a, 8'h00);
        rd(8'h4c, 8'h00);
        rd(8'h4d, 8'h00);
        rd(8'h4e, 8'h00);
        rd(8'h4f, 8'h00);
        rd(8'h70, 8'h00);
        rd(8'h71, 8'h00);
        $display("test reset_values done");
        wr(8'h4a, 8'ha7);
        chk(dim3, 8'ha7);
        rd(8'h4a, 8'ha7);
        wr(8'h4c, 8'hff);
        wr(8'h4d, 8'hd5);
        wr(8'h4e, 8'h80);
        chk({1'b0, st1}, 8'h7f);
        chk({1'b0, st2}, 8'h55);
        chk({1'b0, st3}, 8'h00);
        rd(8'h4c, 8'h7f);
        rd(8'h4d, 8'h55);
        rd(8'h4e, 8'h00);
        rd(8'h4b, 8'h00);
        $display("test rw_masks done");
        for (int p = 0; p < 8; p++) begin
            wr(8'h4f, {5'h1f, p[2:0]});
            chk({5'h00, page}, {5'h00, p[2:0]});
            wr(8'h50, {1'b1, p[2:0], 4'h0});
            wr(8'h5f, {1'b0, p[2:0], 4'hf});
            chk(crd_data, {1'b1, p[2:0], 4'hf});
        end
        for (int p = 0; p < 8; p++) begin
            wr(8'h4f, {5'h00, p[2:0]});
            rd(8'h4f, {5'h00, p[2:0]});
            rd(8'h50, (p < 6) ? {1'b1, p[2:0], 4'h0} : 8'h00);
            rd(8'h5f, (p < 6) ? {1'b0, p[2:0], 4'hf} : 8'h00);
        end
        $display("test code_pages done");
        map = '{aux: 1'b0, outs: 9'h1a5};
        repeat (2) @(negedge clk_sys);
        rd(8'h70, 8'h01);
        rd(8'h71, 8'ha5);
        wr(8'h70, 8'hff);
        wr(8'h71, 8'h00);
        rd(8'h70, 8'h01);
        rd(8'h71, 8'ha5);
        map = '{aux: 1'b1, outs: 9'h05a};
        repeat (2) @(negedge clk_sys);
        rd(8'h70, 8'h80);
        rd(8'h71, 8'h5a);
        $display("test engine_map done");
        srst = 1'b1;
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        rd(8'h4a, 8'h00);
        rd(8'h4f, 8'h00);
        chk({1'b0, st1}, 8'h00);
        $display("test mid_reset done");
        end_of_test();
    end
endmodule : lec_config_regs_tb
